// ==== dv/code_time_converter_tb_top.sv ====
// Self-checking testbench of the code and time converter
`default_nettype none
module code_time_converter_tb_top
  import ctc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int S = 16;
  localparam int D = 64;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [BUS_AW-1:0] busAddr;
  logic [15:0] busWrData;
  logic busWrEn;
  logic busRdEn;
  logic [15:0] dout;
  logic convEn;
  logic busy;
  logic fault;
  logic range_exceeded_flag;
  logic zero;
  logic rdSeen = 1'b0;
  logic [15:0] expq[$];
  int error_cnt = 0;
  int total_checks = 0;
  always #50 ref_clk = ~ref_clk;
  ctc_core dut (.ref_clk(ref_clk), .rstn(rstn), .busAddr(busAddr),
    .busWrData(busWrData), .busWrEn(busWrEn), .busRdEn(busRdEn),
    .busRdData_ff(dout), .convEn(convEn), .busy_ff(busy),
    .faultOut_ff(fault), .rangeExceeded_ff(range_exceeded_flag), .zeroResult_ff(zero));
  ctc_seq_model m (.ref_clk(ref_clk), .busAddr(busAddr),
    .busWrData(busWrData), .busWrEn(busWrEn), .busRdEn(busRdEn),
    .convEn(convEn), .busy_ff(busy));
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Read data appear in the cycle after the read strobe and are held until the next read
  always @(posedge ref_clk) begin
    if (rdSeen) chk(dout, expq.pop_front());
    rdSeen <= busRdEn;
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    tally_and_finish();
  end
  //////////////////////////////////////////////////////////////////////
  task automatic wr(input int a, input logic [15:0] d);
    m.xfer(1'b1, 10'(a), d);
  endtask
  task automatic mw(input int i, input logic [15:0] d);
    wr(512 + i, d);
  endtask
  // Register read; the memory window is selected by address bit 9
  task automatic rr(input int a, input logic [15:0] e);
    expq.push_back(e);
    m.xfer(1'b0, 10'(a), 16'h0000);
  endtask
  task automatic mr(input int i, input logic [15:0] e);
    rr(512 + i, e);
  endtask
  // Flags given as {zero, over-range, fault}; busy must read back low
  task automatic flags(input logic [2:0] f);
    rr(int'(REG_STAT), {13'h0000, f});
    @(negedge ref_clk);
    chk({13'h0000, zero, range_exceeded_flag, fault}, {13'h0000, f});
    @(posedge ref_clk);
    wr(int'(REG_STAT), 16'h0007);
  endtask
  task automatic op(input logic [2:0] o, input logic [2:0] dg,
                    input logic p, input logic [15:0] cnt);
    wr(int'(REG_CTRL), {9'h000, dg, p, o});
    wr(int'(REG_SRC), 16'(S));
    wr(int'(REG_DST), 16'(D));
    wr(int'(REG_CNT), cnt);
    m.run(p);
    // held enable leaves the engine idle
    @(negedge ref_clk);
    chk(16'(busy), 16'h0000);
    @(posedge ref_clk);
  endtask
  function automatic logic [7:0] seg(input logic [3:0] n);
    logic [127:0] t;
    t = 128'h7E306D79335B5F727F7B771F4E3D4F47;
    return t[127-8*n -: 8];
  endfunction
  task automatic hexcase(input string t);
    logic [15:0] e[2];
    logic f;
    int p;
    e = '{16'hFFFF, 16'hFFFF};
    f = 1'b0;
    for (int i = 0; i < t.len(); i++) begin
      mw(S + i, {8'($urandom), t[i]});
      p = t.len() - 1 - i;
      if (t[i] inside {[8'h30:8'h39]}) e[p/4][p%4*4 +: 4] = 4'(t[i] - 8'h30);
      else if (t[i] inside {[8'h41:8'h46]})
        e[p/4][p%4*4 +: 4] = 4'(t[i] - 8'h37);
      else f = 1'b1;
    end
    mw(D, 16'hFFFF);
    mw(D + 1, 16'hFFFF);
    op(OP_HEX, 3'h0, f, 16'(t.len()));
    mr(D, e[0]);
    mr(D + 1, e[1]);
    if (t.len() > 0) flags({2'b00, f});
    else wr(int'(REG_STAT), 16'h0007);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    int tc[3];
    int sv[5];
    void'($urandom(32'hE4BE));
    tc = '{3, 12, 13};
    sv = '{0, 117964799, -117968399, 117964800, -117968400};
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    flags(3'b000);
    for (int i = 0; i < 9; i++) begin
      logic [15:0] s;
      logic [2:0] dg;
      logic [15:0] w0;
      logic [15:0] w1;
      s = (i < 4) ? 16'h3210 + 16'(i) * 16'h4444 : 16'($urandom);
      dg = (i < 4) ? 3'h3 : 3'(i - 4);
      w0 = 16'hA5A5;
      w1 = 16'hA5A5;
      if (dg < 4) w0[7:0] = seg(s[3:0]);
      if (dg inside {[1:3]}) w0[15:8] = seg(s[7:4]);
      if (dg inside {[2:3]}) w1[7:0] = seg(s[11:8]);
      if (dg == 3) w1[15:8] = seg(s[15:12]);
      mw(S, s);
      mw(D, 16'hA5A5);
      mw(D + 1, 16'hA5A5);
      op(OP_SEG, dg, i[0], 16'h0000);
      mr(D, w0);
      mr(D + 1, w1);
      flags({2'b00, dg == 3'h4});
    end
    for (int j = 0; j < 6; j++)
      wr(int'(REG_TEXT0) + j, {8'(65 + 2*j), 8'(66 + 2*j)});
    foreach (tc[k]) begin
      for (int j = 0; j < 6; j++) mw(D + j, 16'hA5A5);
      op(OP_ASC, 3'h0, k[0], 16'(tc[k]));
      for (int j = 0; j < 6; j++) begin
        logic [15:0] e;
        e = 16'hA5A5;
        if (tc[k] <= 12 && 2*j + 1 < tc[k]) e = {8'(65 + 2*j), 8'(66 + 2*j)};
        else if (tc[k] <= 12 && 2*j < tc[k]) e = {8'(65 + 2*j), 8'h00};
        mr(D + j, e);
      end
      flags({2'b00, tc[k] > 12});
    end
    for (int i = 0; i < 5; i++) begin
      int h;
      int mi;
      int s;
      int v;
      h = i ? int'($urandom_range(0, 60000)) - 30000 : 0;
      mi = i ? int'($urandom_range(0, 2000)) - 1000 : 0;
      s = i ? int'($urandom_range(0, 2000)) - 1000 : 0;
      v = h * 3600 + mi * 60 + s;
      mw(S, 16'(s));
      mw(S + 1, 16'(mi));
      mw(S + 2, 16'(h));
      op(OP_TOSEC, 3'h0, i[0], 16'h0000);
      mr(D, v[15:0]);
      mr(D + 1, v[31:16]);
      flags({v == 0, 2'b00});
    end
    for (int i = 0; i < 7; i++) begin
      int v;
      logic ov;
      v = i < 5 ? sv[i] : int'($urandom_range(0, 200000000)) - 100000000;
      ov = v > 117964799 || v < -117968399;
      mw(S, v[15:0]);
      mw(S + 1, v[31:16]);
      for (int j = 0; j < 3; j++) mw(D + j, 16'h5A5A);
      op(OP_SPLIT, 3'h0, i[0], 16'h0000);
      mr(D, ov ? 16'h5A5A : 16'(v % 60));
      mr(D + 1, ov ? 16'h5A5A : 16'((v % 3600) / 60));
      mr(D + 2, ov ? 16'h5A5A : 16'(v / 3600));
      flags({v == 0, ov, 1'b0});
    end
    hexcase("9AE");
    hexcase("123456");
    hexcase("9G");
    hexcase("");
    for (int o = 5; o < 8; o++) begin
      op(3'(o), 3'h0, 1'b0, 16'h0000);
      flags(3'b001);
    end
    repeat (4) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== dv/ctc_seq_model.sv ====
// Sequencer model: drives the register port and the conversion enable
`default_nettype none
module ctc_seq_model
  import ctc_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [BUS_AW-1:0] busAddr,
  output logic [15:0] busWrData,
  output logic busWrEn,
  output logic busRdEn,
  // Conversion control
  output logic convEn,
  input wire logic busy_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    busAddr = '0;
    busWrData = '0;
    busWrEn = 1'b0;
    busRdEn = 1'b0;
    convEn = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////
  // Idle gap after each strobe so no signal is driven twice in a step
  task automatic xfer(input logic w, input logic [BUS_AW-1:0] a,
                      input logic [15:0] d);
    busAddr <= a;
    busWrData <= d;
    busWrEn <= w;
    busRdEn <= !w;
    @(posedge ref_clk);
    busWrEn <= 1'b0;
    busRdEn <= 1'b0;
    @(posedge ref_clk);
  endtask
  //////////////////////////////////////////////////////////////////////
  // enable level or edge
  task automatic run(input logic hold);
    int n;
    n = 0;
    convEn <= 1'b1;
    @(posedge ref_clk);
    if (!hold) convEn <= 1'b0;
    @(negedge ref_clk);
    @(negedge ref_clk);
    while (busy_ff !== 1'b0 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    // Held enable must not restart a pulsed conversion
    repeat (3) @(posedge ref_clk);
    convEn <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ==== verilog/ctc_core.sv ====
// Conversion engine with its data memory and register port
`default_nettype none
// Summary of operation
// R1 - Run while enable is high; pulsed mode runs once per rising edge.
// R2 - Nibbles 0..F map to fixed seven-segment byte codes.
// R3 - Segment byte bit 7 is zero, a at bit 6 down to g at bit 0.
// R4 - Digit field plus one nibbles converted; field above 3 faults and skips.
// R5 - First digit to low byte, second digit to high byte of word one.
// R6 - Third and fourth digits go to next word; unwritten bytes keep contents.
// R7 - Single digit writes only the low byte.
// R8 - Up to 12 stored characters written as ASCII, two per word.
// R9 - Earlier character in upper byte; odd count zero-fills the last byte.
// R10 - Time words read as seconds, minutes, then hours.
// R11 - Time words are signed with bit 15 as sign, two's complement.
// R12 - Result is hours*3600 + minutes*60 + seconds over two words.
// R13 - The 32-bit seconds value is two's complement with bit 31 sign.
// R14 - A zero time-to-seconds result sets the zero flag.
// R15 - Signed seconds from two words split into seconds, minutes, hours.
// R16 - Minutes and seconds stay within -59..59, hours within 16 bits.
// R17 - Seconds outside the allowed range skip the split and flag over-range.
// R18 - A zero seconds source sets the zero flag.
// R19 - Character-to-nibble reads the low byte of each source word.
// R20 - Four nibbles per destination word; untouched nibbles keep contents.
// R21 - Last character is least significant, filling nibble 0 upward.
// R22 - Character count of zero or above 511 skips the conversion.
// R23 - A character outside 0-9 and A-F raises the fault output.
// R24 - A skipped conversion leaves all destination words unchanged.
module ctc_core
  import ctc_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register port
  input wire logic [BUS_AW-1:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic busWrEn,
  input wire logic busRdEn,
  output logic [15:0] busRdData_ff,
  // Conversion control and flags
  input wire logic convEn,
  output logic busy_ff,
  output logic faultOut_ff,
  output logic rangeExceeded_ff,
  output logic zeroResult_ff
);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_LOAD  = 5'b00010,
    ST_CHECK = 5'b00100,
    ST_STORE = 5'b01000,
    ST_FIN   = 5'b10000
  } ctc_state_e;

  function automatic logic [7:0] segment_encode(input logic [3:0] nib);
    segment_encode = SEG_TAB[nib];
  endfunction

  // Returns {valid, nibble}
  function automatic logic [4:0] char_to_nibble(input logic [7:0] ch);
    logic [7:0] v;
    v = 8'h00;
    char_to_nibble = 5'h00;
    if (ch >= CH_0 && ch <= CH_9) begin
      v = ch - CH_0;
      char_to_nibble = {1'b1, v[3:0]};
    end else if (ch >= CH_A && ch <= CH_F) begin
      v = ch - CH_A_OFS;
      char_to_nibble = {1'b1, v[3:0]};
    end
  endfunction

  logic [15:0] memArr [2**AW];
  logic [15:0] ctrl_ff;
  logic [AW-1:0] src_ff;
  logic [AW-1:0] dst_ff;
  logic [8:0] cnt_ff;
  logic [15:0] text_ff [TEXT_WORDS];
  ctc_flags_s flags_ff;
  ctc_state_e state_ff;
  logic [8:0] idx_ff;
  logic signed [31:0] acc_ff;
  logic enPrev_ff;
  logic pend_ff;

  logic [2:0] opSel;
  logic [2:0] digits;
  logic pulsed;
  logic regWr;
  logic [3:0] regIdx;
  logic startReq;
  logic [AW-1:0] srcPtr;
  logic [AW-1:0] dstPtr;
  logic [8:0] nibPos;
  logic [15:0] srcWord;
  logic [15:0] memSrc;
  logic [15:0] memDst;
  logic [8:0] loadLast;
  logic [8:0] storeLast;
  logic needLoad;
  logic skipOp;
  logic engWe;
  logic [15:0] engData;
  ctc_flags_s setFlags;
  logic signed [31:0] loadTerm;
  logic signed [31:0] hrsQ;
  logic signed [31:0] remH;
  logic signed [31:0] minQ;
  logic signed [31:0] secR;
  logic [4:0] hexNib;
  logic [8:0] ascWords;

  assign opSel = ctrl_ff[CTRL_OP_LSB +: 3];
  assign digits = ctrl_ff[CTRL_DIG_LSB +: 3];
  assign pulsed = ctrl_ff[CTRL_PULSED_BIT];
  assign regWr = busWrEn && !busAddr[MEM_SEL_BIT];
  assign regIdx = busAddr[3:0];
  assign nibPos = cnt_ff - 9'd1 - idx_ff;
  assign srcPtr = src_ff + idx_ff[AW-1:0];
  assign dstPtr = (opSel == OP_HEX) ? dst_ff + AW'(nibPos >> 2)
                                    : dst_ff + idx_ff[AW-1:0];
  assign srcWord = memArr[src_ff];
  assign memSrc = memArr[srcPtr];
  assign memDst = memArr[dstPtr];
  assign hexNib = char_to_nibble(memSrc[7:0]);
  assign ascWords = (cnt_ff + 9'd1) >> 1;

  ////////////////////////////////////////////////////////////////////////////
  // Start control

  // R1 level or edge start
  assign startReq = (state_ff == ST_IDLE) && (pulsed ? pend_ff : convEn);

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      enPrev_ff <= 1'b0;
      pend_ff <= 1'b0;
    end else begin
      enPrev_ff <= convEn;
      // A rise seen while busy is kept for the next idle cycle
      if (pulsed && convEn && !enPrev_ff) begin
        pend_ff <= 1'b1;
      end else if (startReq || !pulsed) begin
        pend_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ctrl_ff <= CTRL_RESET;
      src_ff <= '0;
      dst_ff <= '0;
      cnt_ff <= 9'h000;
    end else if (regWr) begin
      case (regIdx)
        REG_CTRL: ctrl_ff <= busWrData;
        REG_SRC: src_ff <= busWrData[AW-1:0];
        REG_DST: dst_ff <= busWrData[AW-1:0];
        REG_CNT: cnt_ff <= busWrData[8:0];
        default: ;
      endcase
    end
  end

  for (genvar g = 0; g < TEXT_WORDS; g++) begin : gText
    always_ff @(posedge ref_clk) begin
      if (!rstn) begin
        text_ff[g] <= 16'h0000;
      end else if (regWr && regIdx == REG_TEXT0 + 4'(g)) begin
        text_ff[g] <= busWrData;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      busRdData_ff <= 16'h0000;
    end else if (busRdEn) begin
      busRdData_ff <= 16'h0000;
      if (busAddr[MEM_SEL_BIT]) begin
        busRdData_ff <= memArr[busAddr[AW-1:0]];
      end else begin
        case (regIdx)
          REG_CTRL: busRdData_ff <= ctrl_ff;
          REG_SRC: busRdData_ff <= 16'(src_ff);
          REG_DST: busRdData_ff <= 16'(dst_ff);
          REG_CNT: busRdData_ff <= 16'(cnt_ff);
          REG_STAT: busRdData_ff <= 16'({busy_ff, flags_ff.zero,
                                         flags_ff.overRange, flags_ff.fault});
          default: begin
            if (regIdx >= REG_TEXT0 &&
                regIdx < REG_TEXT0 + 4'(TEXT_WORDS)) begin
              busRdData_ff <= text_ff[3'(regIdx - REG_TEXT0)];
            end
          end
        endcase
      end
    end
  end

  // Engine writes win over a bus write in the same cycle
  always_ff @(posedge ref_clk) begin
    if (engWe) begin
      memArr[dstPtr] <= engData;
    end else if (busWrEn && busAddr[MEM_SEL_BIT]) begin
      memArr[busAddr[AW-1:0]] <= busWrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing

  always_comb begin
    needLoad = 1'b0;
    loadLast = 9'd0;
    storeLast = 9'd0;
    skipOp = 1'b0;
    setFlags = '0;
    case (opSel)
      OP_SEG: begin
        // R4 digit field check
        skipOp = digits > SEG_MAX_DIG;
        storeLast = (digits >= 3'd2) ? 9'd1 : 9'd0;
        setFlags.fault = skipOp;
      end
      OP_ASC: begin
        // R8 at most twelve characters
        skipOp = (cnt_ff == 9'd0) || (cnt_ff > ASC_MAX_CHARS);
        storeLast = ascWords - 9'd1;
        setFlags.fault = skipOp;
      end
      OP_TOSEC: begin
        needLoad = 1'b1;
        loadLast = 9'd2;
        storeLast = 9'd1;
        // R14 zero result
        setFlags.zero = (acc_ff == 32'sd0);
      end
      OP_SPLIT: begin
        needLoad = 1'b1;
        loadLast = 9'd1;
        storeLast = 9'd2;
        // R17 range check
        skipOp = (acc_ff < SPLIT_MIN) || (acc_ff > SPLIT_MAX);
        setFlags.overRange = skipOp;
        // R18 zero source
        setFlags.zero = (acc_ff == 32'sd0);
      end
      OP_HEX: begin
        // R22 character count
        skipOp = (cnt_ff == 9'd0) || (cnt_ff > HEX_MAX_CHARS);
        storeLast = cnt_ff - 9'd1;
      end
      default: begin
        skipOp = 1'b1;
        setFlags.fault = 1'b1;
      end
    endcase
  end

  // R10 R11 seconds, minutes, hours weighted in order
  always_comb begin
    case (idx_ff[1:0])
      2'd0: loadTerm = 32'(signed'(memSrc));
      2'd1: loadTerm = 32'(signed'(memSrc) * SEC_PER_MIN);
      default: loadTerm = 32'(signed'(memSrc) * SEC_PER_HOUR);
    endcase
  end

  // R16 truncating division keeps each part in range
  assign hrsQ = acc_ff / SEC_PER_HOUR;
  assign remH = acc_ff % SEC_PER_HOUR;
  assign minQ = remH / SEC_PER_MIN;
  assign secR = remH % SEC_PER_MIN;

  always_comb begin
    engWe = 1'b0;
    engData = memDst;
    if (state_ff == ST_STORE) begin
      engWe = 1'b1;
      case (opSel)
        OP_SEG: begin
          // R2 R3 R5 R6 R7 byte placement
          if (idx_ff == 9'd0) begin
            engData[7:0] = segment_encode(srcWord[3:0]);
            if (digits >= 3'd1) begin
              engData[15:8] = segment_encode(srcWord[7:4]);
            end
          end else begin
            engData[7:0] = segment_encode(srcWord[11:8]);
            if (digits == 3'd3) begin
              engData[15:8] = segment_encode(srcWord[15:12]);
            end
          end
        end
        OP_ASC: begin
          // R9 packing and zero fill
          engData = text_ff[3'(idx_ff)];
          if (cnt_ff[0] && idx_ff == storeLast) begin
            engData[7:0] = 8'h00;
          end
        end
        OP_TOSEC: begin
          // R12 R13 low word first
          engData = idx_ff[0] ? acc_ff[31:16] : acc_ff[15:0];
        end
        OP_SPLIT: begin
          // R15 seconds, minutes, hours
          case (idx_ff[1:0])
            2'd0: engData = secR[15:0];
            2'd1: engData = minQ[15:0];
            default: engData = hrsQ[15:0];
          endcase
        end
        OP_HEX: begin
          // R19 R20 R21 low byte into one nibble
          engWe = hexNib[4];
          engData[{nibPos[1:0], 2'b00} +: 4] = hexNib[3:0];
        end
        default: engWe = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      idx_ff <= 9'd0;
      acc_ff <= 32'sd0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          idx_ff <= 9'd0;
          acc_ff <= 32'sd0;
          if (startReq) begin
            state_ff <= needLoad ? ST_LOAD : ST_CHECK;
          end
        end
        ST_LOAD: begin
          if (opSel == OP_TOSEC) begin
            acc_ff <= acc_ff + loadTerm;
          end else if (idx_ff[0]) begin
            acc_ff[31:16] <= memSrc;
          end else begin
            acc_ff[15:0] <= memSrc;
          end
          idx_ff <= (idx_ff == loadLast) ? 9'd0 : idx_ff + 9'd1;
          if (idx_ff == loadLast) begin
            state_ff <= ST_CHECK;
          end
        end
        // R24 skipped operations never enter the store phase
        ST_CHECK: state_ff <= skipOp ? ST_FIN : ST_STORE;
        ST_STORE: begin
          idx_ff <= idx_ff + 9'd1;
          if (idx_ff == storeLast) begin
            state_ff <= ST_FIN;
          end
        end
        ST_FIN: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags: hardware set wins over a software clear in the same cycle

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flags_ff <= '0;
      busy_ff <= 1'b0;
      faultOut_ff <= 1'b0;
      rangeExceeded_ff <= 1'b0;
      zeroResult_ff <= 1'b0;
    end else begin
      if (regWr && regIdx == REG_STAT) begin
        if (busWrData[STAT_FAULT_BIT]) flags_ff.fault <= 1'b0;
        if (busWrData[STAT_OVR_BIT]) flags_ff.overRange <= 1'b0;
        if (busWrData[STAT_ZERO_BIT]) flags_ff.zero <= 1'b0;
      end
      if (state_ff == ST_CHECK) begin
        if (setFlags.fault) flags_ff.fault <= 1'b1;
        if (setFlags.overRange) flags_ff.overRange <= 1'b1;
        if (setFlags.zero) flags_ff.zero <= 1'b1;
      end
      // R23 bad character raises fault
      if (state_ff == ST_STORE && opSel == OP_HEX && !hexNib[4]) begin
        flags_ff.fault <= 1'b1;
      end
      busy_ff <= (state_ff != ST_IDLE) || startReq;
      faultOut_ff <= flags_ff.fault;
      rangeExceeded_ff <= flags_ff.overRange;
      zeroResult_ff <= flags_ff.zero;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_pulse_edge_start: assert property ( // R1
    state_ff == ST_IDLE && pulsed && !convEn |=> state_ff == ST_IDLE
      || pend_ff == 1'b0)
    else $error("pulsed mode started without a rising edge");
  a_level_run_start: assert property ( // R1
    state_ff == ST_IDLE && !pulsed && convEn |=> state_ff != ST_IDLE)
    else $error("level enable did not start a conversion");
  a_seg_bit_seven: assert property ( // R3
    engWe && opSel == OP_SEG |-> engData[7] == 1'b0)
    else $error("segment byte bit 7 not zero");
  a_seg_digit_skip: assert property ( // R4
    state_ff == ST_CHECK && opSel == OP_SEG && digits > SEG_MAX_DIG
      |=> state_ff == ST_FIN && !engWe ##1 flags_ff.fault)
    else $error("bad digit field not skipped with fault");
  a_seg_single_keep: assert property ( // R7
    engWe && opSel == OP_SEG && digits == 3'd0
      |-> engData[15:8] == memDst[15:8]
        && engData[7:0] == SEG_TAB[srcWord[3:0]])
    else $error("single digit touched high byte");
  a_tosec_zero_flag: assert property ( // R14
    state_ff == ST_CHECK && opSel == OP_TOSEC && acc_ff == 32'sd0
      |=> flags_ff.zero ##2 zeroResult_ff)
    else $error("zero seconds result not flagged");
  a_split_range_skip: assert property ( // R17
    state_ff == ST_CHECK && opSel == OP_SPLIT && acc_ff > SPLIT_MAX
      |=> flags_ff.overRange && state_ff == ST_FIN ##1 !engWe)
    else $error("out of range split not skipped");
  a_hex_bad_char: assert property ( // R23
    state_ff == ST_STORE && opSel == OP_HEX && !hexNib[4]
      |-> !engWe ##2 faultOut_ff)
    else $error("bad hex character did not raise fault");
  a_asc_odd_fill: assert property ( // R9
    engWe && opSel == OP_ASC && cnt_ff[0] && idx_ff == storeLast
      |-> engData[7:0] == 8'h00)
    else $error("odd text tail not zero filled");

endmodule
`default_nettype wire

// ==== verilog/ctc_pkg.sv ====
// Shared constants and types of the code and time converter
`default_nettype none
package ctc_pkg;
  // Address map (word indices on the plain register port)
  localparam int BUS_AW = 10;
  localparam int MEM_SEL_BIT = 9;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_SRC = 4'h1;
  localparam logic [3:0] REG_DST = 4'h2;
  localparam logic [3:0] REG_CNT = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_TEXT0 = 4'h8;
  localparam int TEXT_WORDS = 6;
  // Control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_PULSED_BIT = 3;
  localparam int CTRL_DIG_LSB = 4;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // Status register fields
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_OVR_BIT = 1;
  localparam int STAT_ZERO_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  // Operation codes
  localparam logic [2:0] OP_SEG = 3'h0;
  localparam logic [2:0] OP_ASC = 3'h1;
  localparam logic [2:0] OP_TOSEC = 3'h2;
  localparam logic [2:0] OP_SPLIT = 3'h3;
  localparam logic [2:0] OP_HEX = 3'h4;
  // Limits
  localparam logic [2:0] SEG_MAX_DIG = 3'h3;
  localparam logic [8:0] ASC_MAX_CHARS = 9'h00C;
  localparam logic [8:0] HEX_MAX_CHARS = 9'h1FF;
  localparam logic signed [31:0] SPLIT_MIN = -32'sd117968399;
  localparam logic signed [31:0] SPLIT_MAX = 32'sd117964799;
  localparam logic signed [31:0] SEC_PER_MIN = 32'sd60;
  localparam logic signed [31:0] SEC_PER_HOUR = 32'sd3600;
  // Segment codes, bit 6 = a down to bit 0 = g, bit 7 unused
  localparam logic [7:0] SEG_TAB [16] = '{
    8'h7E, 8'h30, 8'h6D, 8'h79, 8'h33, 8'h5B, 8'h5F, 8'h72,
    8'h7F, 8'h7B, 8'h77, 8'h1F, 8'h4E, 8'h3D, 8'h4F, 8'h47};
  // Hex character ranges
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_F = 8'h46;
  localparam logic [7:0] CH_A_OFS = 8'h37;
  typedef struct packed {
    logic fault;
    logic overRange;
    logic zero;
  } ctc_flags_s;
endpackage
`default_nettype wire
